// ===== core/scfg_top.sv
/*
 * holds: serial control port slave with the port configuration,
 * identification, readback select and nv store control registers.
 * assumes: sclk, cs_n, data pin and i2c strap are asynchronous and
 * sampled by clk_i; sclk is much slower than clk_i; nv store
 * sequencer signals share clk_i.
 */
// Function
// - bit 7 picks shared or separate readout pin
// - bit 6 sets bit order and address step
// - i2c mode ignores bit order setting
// - soft reset restores register defaults
// - soft reset bit clears next serial clock
// - read only silicon revision register
// - read only variant identifier register
// - readback select picks staged or active bank
// - single bit field holds readback selection
`timescale 1ns/1ps
`include "scfg_params.svh"
module scfg_top
    import scfg_pkg::*;
#(
    parameter logic [7:0] REVISION = 8'h01, // arbitrary value
    parameter logic [7:0] VARIANT_ID = 8'h5A // arbitrary value
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // serial port pins
    input wire logic sclk_i,
    input wire logic cs_n_i,
    input wire logic sdio_i,
    output logic sdio_o,
    output logic sdio_oe_n_o,
    output logic serial_readout_pin_o,
    output logic serial_readout_pin_oe_n_o,
    // strap
    input wire logic i2c_mode_i,
    // device side
    input wire logic io_update_i,
    output logic soft_reset_o,
    output logic readback_active_o,
    // nv store sequencer
    input wire logic nv_busy_i,
    input wire logic nv_error_i,
    output logic nv_load_start_o,
    output logic regs_to_nv_store_copy_o,
    output logic nv_write_en_o
);
    // ****************************************************
    // pin synchronisers
    // ****************************************************
    logic sclk_s1_r, sclk_s2_r, sclk_d_r; // sclk chain plus edge tap
    logic cs_s1_r, cs_s2_r; // select chain
    logic din_s1_r, din_s2_r; // data pin chain
    logic i2c_s1_r, i2c_s2_r; // strap chain
    logic rise, fall, active; // decoded pin events

    // two flops per pin before any logic reads it
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sclk_s1_r <= 1'b0;
            sclk_s2_r <= 1'b0;
            sclk_d_r <= 1'b0;
            cs_s1_r <= 1'b1;
            cs_s2_r <= 1'b1;
            din_s1_r <= 1'b0;
            din_s2_r <= 1'b0;
            i2c_s1_r <= 1'b0;
            i2c_s2_r <= 1'b0;
        end else begin
            sclk_s1_r <= sclk_i;
            sclk_s2_r <= sclk_s1_r;
            sclk_d_r <= sclk_s2_r;
            cs_s1_r <= cs_n_i;
            cs_s2_r <= cs_s1_r;
            din_s1_r <= sdio_i;
            din_s2_r <= din_s1_r;
            i2c_s1_r <= i2c_mode_i;
            i2c_s2_r <= i2c_s1_r;
        end
    end

    // edges seen only on the settled copy
    assign rise = sclk_s2_r & ~sclk_d_r;
    assign fall = ~sclk_s2_r & sclk_d_r;
    assign active = ~cs_s2_r;

    // ****************************************************
    // state
    // ****************************************************
    scfg_state_t st_r, st_nxt; // transfer phase
    logic [3:0] cnt_r, cnt_nxt; // bit counter
    logic [15:0] sh_r, sh_nxt; // receive shifter
    logic [12:0] addr_r, addr_nxt; // current register address
    logic rd_r, rd_nxt; // transfer is a read
    logic [1:0] left_r, left_nxt; // bytes left, 3 streams
    logic [7:0] tx_r, tx_nxt; // readout shifter
    logic out_r, out_nxt; // bit on the pin
    logic drv_r, drv_nxt; // readout phase active
    logic rdo_r, rdo_nxt; // separate readout pin enable
    logic lsb_r, lsb_nxt; // lsb first, address increments
    logic srst_r, srst_nxt; // soft reset bit as read
    logic arm_r, arm_nxt; // soft reset write completed
    logic spls_r, spls_nxt; // soft reset pulse
    logic rbk_r, rbk_nxt; // readback select
    logic wstg_r, wstg_nxt; // staged write enable
    logic wact_r, wact_nxt; // active write enable
    logic load_r, load_nxt; // soft load request
    logic copy_r, copy_nxt; // copy request
    logic lpls_r, lpls_nxt; // soft load start pulse
    logic cpls_r, cpls_nxt; // copy start pulse
    logic lsb_eff; // bit order after i2c override
    logic [15:0] sh_in; // shifter with the new bit
    logic [7:0] byte_in; // assembled data byte
    // defaults held at full width so single fields are picked, not truncated
    localparam logic [7:0] CFG_DEF = `SCFG_CFG_RST; // port config defaults
    localparam logic [7:0] RBK_DEF = `SCFG_RBK_RST; // readback select default
    localparam logic [7:0] NV_DEF = `SCFG_NV_RST; // nv control defaults

    // i2c framing has its own fixed order
    assign lsb_eff = lsb_r & ~i2c_s2_r;

    // ****************************************************
    // read decode
    // ****************************************************
    // register value seen by a read at address a
    function automatic logic [7:0] rd_val(input logic [12:0] a);
        logic [7:0] v;
        v = 8'h00;
        unique case (a)
            // lower nibble shows the mirrored upper nibble
            `SCFG_ADR_CFG: v = {rdo_r, lsb_r, srst_r, 1'b0,
                1'b0, srst_r, lsb_r, rdo_r};
            `SCFG_ADR_REV: v = REVISION;
            `SCFG_ADR_VID: v = VARIANT_ID;
            `SCFG_ADR_RBK: v = {7'h00, rbk_r};
            `SCFG_ADR_NVST: v = {7'h00, nv_busy_i};
            `SCFG_ADR_NVER: v = {7'h00, nv_error_i};
            // bank chosen by the select bit
            `SCFG_ADR_NVC1: v = {6'h00, load_r, rbk_r ? wact_r : wstg_r};
            `SCFG_ADR_NVC2: v = {7'h00, copy_r};
            default: v = 8'h00; // unmapped reads zero
        endcase
        return v;
    endfunction : rd_val

    // ****************************************************
    // next state
    // ****************************************************
    // one process for the whole bank keeps the write and reset
    // priority in one place
    always_comb begin
        st_nxt = st_r;
        cnt_nxt = cnt_r;
        sh_nxt = sh_r;
        addr_nxt = addr_r;
        rd_nxt = rd_r;
        left_nxt = left_r;
        tx_nxt = tx_r;
        out_nxt = out_r;
        drv_nxt = drv_r;
        rdo_nxt = rdo_r;
        lsb_nxt = lsb_r;
        srst_nxt = srst_r;
        arm_nxt = arm_r;
        spls_nxt = 1'b0;
        rbk_nxt = rbk_r;
        wstg_nxt = wstg_r;
        wact_nxt = wact_r;
        load_nxt = load_r;
        copy_nxt = copy_r;
        lpls_nxt = 1'b0;
        cpls_nxt = 1'b0;
        // shift direction follows the bit order
        sh_in = lsb_eff ? {din_s2_r, sh_r[15:1]} : {sh_r[14:0], din_s2_r};
        byte_in = lsb_eff ? sh_in[15:8] : sh_in[7:0];
        // self clearing starts, cleared once issued
        if (load_r) begin
            load_nxt = 1'b0;
            lpls_nxt = 1'b1;
        end
        if (copy_r) begin
            copy_nxt = 1'b0;
            cpls_nxt = 1'b1;
        end
        // staged enable becomes active on update
        if (io_update_i) begin
            wact_nxt = wstg_r;
        end
        // soft reset fires on the next serial clock rise
        if (arm_r && rise) begin
            arm_nxt = 1'b0;
            spls_nxt = 1'b1;
        end
        if (!active) begin
            // deselect ends any transfer
            st_nxt = ST_IDLE;
            cnt_nxt = 4'h0;
            drv_nxt = 1'b0;
        end else if (fall && drv_r) begin
            // pop one readout bit per falling edge
            out_nxt = lsb_eff ? tx_r[0] : tx_r[7];
            tx_nxt = lsb_eff ? {1'b0, tx_r[7:1]} : {tx_r[6:0], 1'b0};
        end else begin
            unique case (st_r)
                ST_IDLE: begin
                    st_nxt = ST_INSTR;
                    cnt_nxt = 4'h0;
                end
                ST_INSTR: begin
                    if (rise) begin
                        sh_nxt = sh_in;
                        cnt_nxt = cnt_r + 4'h1;
                        // instruction word complete
                        if (cnt_r == `SCFG_INS_LAST) begin
                            rd_nxt = sh_in[`SCFG_INS_RW];
                            left_nxt = sh_in[14:13];
                            addr_nxt = sh_in[12:0];
                            st_nxt = ST_DATA;
                            cnt_nxt = 4'h0;
                            tx_nxt = rd_val(sh_in[12:0]);
                            drv_nxt = sh_in[`SCFG_INS_RW];
                        end
                    end
                end
                ST_DATA: begin
                    if (rise) begin
                        sh_nxt = sh_in;
                        cnt_nxt = cnt_r + 4'h1;
                        if (cnt_r == `SCFG_BYTE_LAST) begin
                            cnt_nxt = 4'h0;
                            if (!rd_r) begin
                                // byte write, mirror nibble not checked
                                unique case (addr_r)
                                    `SCFG_ADR_CFG: begin
                                        rdo_nxt = byte_in[`SCFG_CFG_RDO];
                                        lsb_nxt = byte_in[`SCFG_CFG_LSB];
                                        srst_nxt = byte_in[`SCFG_CFG_SRST];
                                        arm_nxt = byte_in[`SCFG_CFG_SRST];
                                    end
                                    `SCFG_ADR_RBK: begin
                                        rbk_nxt = byte_in[`SCFG_RBK_SEL];
                                    end
                                    `SCFG_ADR_NVC1: begin
                                        // set wins over self clear
                                        load_nxt = byte_in[`SCFG_NVC1_LOAD];
                                        wstg_nxt = byte_in[`SCFG_NVC1_WEN];
                                    end
                                    `SCFG_ADR_NVC2: begin
                                        // request dropped without enable
                                        copy_nxt = byte_in[`SCFG_NVC2_COPY] & wact_r;
                                    end
                                    default: begin
                                        // read only or unmapped
                                    end
                                endcase
                            end
                            // address steps per bit order
                            addr_nxt = lsb_eff ? addr_r + 13'h1 : addr_r - 13'h1;
                            if (left_r == 2'h0) begin
                                st_nxt = ST_DONE;
                                drv_nxt = 1'b0;
                            end else begin
                                if (left_r != `SCFG_STREAM) begin
                                    left_nxt = left_r - 2'h1;
                                end
                                tx_nxt = rd_val(addr_nxt);
                            end
                        end
                    end
                end
                ST_DONE: begin
                    // wait for deselect
                end
            endcase
        end
        // soft reset overrides everything it covers
        if (spls_nxt) begin
            rdo_nxt = CFG_DEF[`SCFG_CFG_RDO];
            lsb_nxt = CFG_DEF[`SCFG_CFG_LSB];
            srst_nxt = 1'b0;
            rbk_nxt = RBK_DEF[`SCFG_RBK_SEL];
            wstg_nxt = NV_DEF[`SCFG_NVC1_WEN];
            wact_nxt = NV_DEF[`SCFG_NVC1_WEN];
            load_nxt = 1'b0;
            copy_nxt = 1'b0;
        end
    end

    // ****************************************************
    // registers
    // ****************************************************
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_r <= ST_IDLE;
            cnt_r <= 4'h0;
            sh_r <= 16'h0000;
            addr_r <= 13'h0000;
            rd_r <= 1'b0;
            left_r <= 2'h0;
            tx_r <= 8'h00;
            out_r <= 1'b0;
            drv_r <= 1'b0;
            rdo_r <= CFG_DEF[`SCFG_CFG_RDO];
            lsb_r <= CFG_DEF[`SCFG_CFG_LSB];
            srst_r <= 1'b0;
            arm_r <= 1'b0;
            spls_r <= 1'b0;
            rbk_r <= RBK_DEF[`SCFG_RBK_SEL];
            wstg_r <= 1'b0;
            wact_r <= 1'b0;
            load_r <= 1'b0;
            copy_r <= 1'b0;
            lpls_r <= 1'b0;
            cpls_r <= 1'b0;
        end else begin
            st_r <= st_nxt;
            cnt_r <= cnt_nxt;
            sh_r <= sh_nxt;
            addr_r <= addr_nxt;
            rd_r <= rd_nxt;
            left_r <= left_nxt;
            tx_r <= tx_nxt;
            out_r <= out_nxt;
            drv_r <= drv_nxt;
            rdo_r <= rdo_nxt;
            lsb_r <= lsb_nxt;
            srst_r <= srst_nxt;
            arm_r <= arm_nxt;
            spls_r <= spls_nxt;
            rbk_r <= rbk_nxt;
            wstg_r <= wstg_nxt;
            wact_r <= wact_nxt;
            load_r <= load_nxt;
            copy_r <= copy_nxt;
            lpls_r <= lpls_nxt;
            cpls_r <= cpls_nxt;
        end
    end

    // ****************************************************
    // outputs
    // ****************************************************
    // enables are low while driving; unused pin floats
    assign sdio_oe_n_o = ~(drv_r & ~rdo_r);
    assign serial_readout_pin_oe_n_o = ~(drv_r & rdo_r);
    assign sdio_o = out_r;
    assign serial_readout_pin_o = out_r;
    assign soft_reset_o = spls_r;
    assign readback_active_o = rbk_r;
    assign nv_load_start_o = lpls_r;
    assign regs_to_nv_store_copy_o = cpls_r;
    assign nv_write_en_o = wact_r;

    // ****************************************************
    // checks
    // ****************************************************
    pin_shared_a: assert property (@(posedge clk_i) disable iff (rst_i)
        !rdo_r |-> serial_readout_pin_oe_n_o)
        else $error("readout pin driven in shared mode");
    pin_split_a: assert property (@(posedge clk_i) disable iff (rst_i)
        rdo_r && drv_r |-> !serial_readout_pin_oe_n_o && sdio_oe_n_o)
        else $error("wrong pin driven in split mode");
    addr_step_a: assert property (@(posedge clk_i) disable iff (rst_i)
        st_r == ST_DATA && active && rise && cnt_r == 4'h7 |=>
        addr_r == ($past(lsb_eff) ? $past(addr_r) + 13'h1 : $past(addr_r) - 13'h1))
        else $error("address step wrong");
    i2c_order_a: assert property (@(posedge clk_i) disable iff (rst_i)
        i2c_s2_r && lsb_r && drv_r && fall && active |=> out_r == $past(tx_r[7]))
        else $error("bit order not ignored in i2c mode");
    srst_clear_a: assert property (@(posedge clk_i) disable iff (rst_i)
        arm_r && rise |=> soft_reset_o && !srst_r ##1 !soft_reset_o)
        else $error("soft reset did not self clear");
    srst_default_a: assert property (@(posedge clk_i) disable iff (rst_i)
        soft_reset_o |-> !rbk_r && !lsb_r && !rdo_r && !wact_r)
        else $error("soft reset left a non default value");
    id_value_a: assert property (@(posedge clk_i) disable iff (rst_i)
        st_r == ST_INSTR && active && rise && cnt_r == `SCFG_INS_LAST &&
        sh_in[12:0] == `SCFG_ADR_VID |=> tx_r == VARIANT_ID)
        else $error("identification value wrong");
    load_clear_a: assert property (@(posedge clk_i) disable iff (rst_i)
        load_r |=> !load_r && nv_load_start_o)
        else $error("soft load not started or not cleared");
    copy_gate_a: assert property (@(posedge clk_i) disable iff (rst_i)
        regs_to_nv_store_copy_o |-> $past(wact_r, 2))
        else $error("copy started without write enable");
endmodule : scfg_top

// ===== core/scfg_params.svh
/*
 * holds: register offsets, field positions, reset values of the
 * serial port configuration and nv store control bank.
 * assumes: included by bare name, 13-bit register addresses.
 */
`ifndef SCFG_PARAMS_SVH
`define SCFG_PARAMS_SVH
// ****************************************************
// register offsets
// ****************************************************
`define SCFG_ADR_CFG 13'h000
`define SCFG_ADR_REV 13'h002
`define SCFG_ADR_VID 13'h003
`define SCFG_ADR_RBK 13'h004
`define SCFG_ADR_NVST 13'hB00
`define SCFG_ADR_NVER 13'hB01
`define SCFG_ADR_NVC1 13'hB02
`define SCFG_ADR_NVC2 13'hB03
// ****************************************************
// field positions
// ****************************************************
`define SCFG_CFG_RDO 7
`define SCFG_CFG_LSB 6
`define SCFG_CFG_SRST 5
`define SCFG_RBK_SEL 0
`define SCFG_NVC1_LOAD 1
`define SCFG_NVC1_WEN 0
`define SCFG_NVC2_COPY 0
`define SCFG_INS_RW 15
`define SCFG_INS_LAST 4'hF
`define SCFG_BYTE_LAST 4'h7
`define SCFG_STREAM 2'h3
// ****************************************************
// reset values
// ****************************************************
`define SCFG_CFG_RST 8'h00
`define SCFG_RBK_RST 8'h00
`define SCFG_NV_RST 8'h00
`endif

// ===== core/scfg_pkg.sv
/*
 * holds: types shared by the serial configuration bank.
 * assumes: nothing beyond the params header.
 */
package scfg_pkg;
    // serial transfer phase
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_INSTR,
        ST_DATA,
        ST_DONE
    } scfg_state_t;
endpackage : scfg_pkg

// ===== tb/scfg_host.sv
/*
 * holds: behavioural host that frames serial transfers to the bank.
 * assumes: clk_i is the bench clock; the bench resolves the shared
 * data wire and the readout pin and feeds them back here.
 */
`timescale 1ns/1ps
module scfg_host (
    // bench clock
    input wire logic clk_i,
    // resolved pins seen by the host
    input wire logic sdio_i,
    input wire logic ro_i,
    // host driven pins
    output logic sclk_o,
    output logic cs_n_o,
    output logic sdio_o
);
    // ****
    // serial clock stands low outside frames
    // ****
    initial begin
        sclk_o = 1'b0;
        cs_n_o = 1'b1;
        sdio_o = 1'b0;
    end

    // one bit: data set after the fall, 160 ns period
    task automatic bit_x(input logic b, input logic drv, input logic sep, output logic r);
        @(negedge clk_i);
        sdio_o = drv ? b : ~sdio_o; // released line never shows old value
        repeat (7) @(negedge clk_i);
        sclk_o = 1'b1;
        r = sep ? ro_i : sdio_i; // read bit settled well before rise
        repeat (8) @(negedge clk_i);
        sclk_o = 1'b0;
    endtask : bit_x

    // one whole frame: instruction then cnt+1 bytes
    task automatic frame(input logic rd, input logic [1:0] cnt, input logic [12:0] adr,
                         input logic [31:0] wd, input logic lsb, input logic sep,
                         output logic [31:0] rq);
        logic [15:0] ins;
        logic r;
        int i;
        int k;
        ins = {rd, cnt, adr};
        rq = '0;
        @(negedge clk_i);
        cs_n_o = 1'b0;
        repeat (4) @(negedge clk_i);
        for (i = 0; i < 16; i++) begin
            bit_x(ins[lsb ? i : 15 - i], 1'b1, sep, r);
        end
        for (i = 0; i < 8 * (int'(cnt) + 1); i++) begin
            k = (i / 8) * 8 + (lsb ? i % 8 : 7 - i % 8);
            bit_x(wd[k], !rd, sep, r);
            rq[k] = r;
        end
        repeat (8) @(negedge clk_i);
        cs_n_o = 1'b1;
        repeat (8) @(negedge clk_i);
    endtask : frame
endmodule : scfg_host

// ===== tb/scfg_top_tb.sv
/*
 * holds: self checking bench of the serial configuration bank.
 * assumes: scfg_host model on the serial pins, 100 MHz clock.
 */
`timescale 1ns/1ps
`include "scfg_params.svh"
module scfg_top_tb;
    localparam logic [7:0] REV = 8'h3C; // arbitrary value
    localparam logic [7:0] VID = 8'hC5; // arbitrary value
    // ****
    // signals
    // ****
    logic clk_i = 1'b0;
    logic rst_i, i2c_mode_i, io_update_i, nv_busy_i, nv_error_i;
    wire logic sclk, cs_n, h_sdio;
    logic sdio_o, sdio_oe_n_o, ro_o, ro_oe_n_o, soft_reset_o, readback_active_o;
    logic nv_load_start_o, copy_o, nv_write_en_o;
    logic lsb, sep; // host framing mode
    logic [31:0] q, seed, x;
    int miscompares = 0, n_compared = 0;
    int n_srst = 0, n_load = 0, n_copy = 0, n_sd = 0, n_ro = 0, s_sd, s_ro, i;
    // wire resolution: an undriven readout pin shows the inverse, an undriven data wire the host value
    wire logic sdio_w = !sdio_oe_n_o ? sdio_o : h_sdio;
    wire logic ro_w = !ro_oe_n_o ? ro_o : ~ro_o;

    always #5 clk_i = ~clk_i;

    scfg_top #(.REVISION(REV), .VARIANT_ID(VID)) u_scfg_top (
        .clk_i(clk_i), .rst_i(rst_i), .sclk_i(sclk), .cs_n_i(cs_n), .sdio_i(sdio_w),
        .sdio_o(sdio_o), .sdio_oe_n_o(sdio_oe_n_o), .serial_readout_pin_o(ro_o),
        .serial_readout_pin_oe_n_o(ro_oe_n_o), .i2c_mode_i(i2c_mode_i),
        .io_update_i(io_update_i), .soft_reset_o(soft_reset_o),
        .readback_active_o(readback_active_o), .nv_busy_i(nv_busy_i),
        .nv_error_i(nv_error_i), .nv_load_start_o(nv_load_start_o),
        .regs_to_nv_store_copy_o(copy_o), .nv_write_en_o(nv_write_en_o));

    scfg_host u_scfg_host (.clk_i(clk_i), .sdio_i(sdio_w), .ro_i(ro_w),
        .sclk_o(sclk), .cs_n_o(cs_n), .sdio_o(h_sdio));

    // pulse and drive counters, seen only on settled outputs
    always @(negedge clk_i) begin
        if (soft_reset_o === 1'b1) n_srst++;
        if (nv_load_start_o === 1'b1) n_load++;
        if (copy_o === 1'b1) n_copy++;
        if (sdio_oe_n_o === 1'b0) n_sd++;
        if (ro_oe_n_o === 1'b0) n_ro++;
    end

    // ****
    // helpers
    // ****
    function automatic logic [31:0] xs(input logic [31:0] v);
        v = v ^ (v << 13);
        v = v ^ (v >> 17);
        return v ^ (v << 5);
    endfunction : xs

    task automatic chk_val(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp) begin
            miscompares++;
            $display("BAD t=%0t value %h expected %h", $time, got, exp);
        end
    endtask : chk_val

    task automatic chk_cnt(input int got, input int exp);
        n_compared++;
        if (got != exp) begin
            miscompares++;
            $display("BAD t=%0t count %0d expected %0d", $time, got, exp);
        end
    endtask : chk_cnt

    task automatic wr(input logic [12:0] a, input logic [7:0] d);
        u_scfg_host.frame(1'b0, 2'h0, a, {24'h0, d}, lsb, sep, q);
    endtask : wr

    task automatic rd(input logic [12:0] a, input logic [7:0] e);
        u_scfg_host.frame(1'b1, 2'h0, a, 32'h0, lsb, sep, q);
        chk_val(q[7:0], e);
    endtask : rd

    task automatic end_of_test;
        $display("compared %0d miscompares %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : end_of_test

    // watchdog: a hang counts as a mismatch
    initial begin
        repeat (100000) @(posedge clk_i);
        miscompares++;
        end_of_test;
    end

    // ****
    // main sequence
    // ****
    initial begin
        {rst_i, i2c_mode_i, io_update_i, nv_busy_i, nv_error_i, lsb, sep} = 7'h40;
        seed = 32'd35;
        repeat (4) @(negedge clk_i);
        rst_i = 1'b0;
        repeat (4) @(negedge clk_i);
        // reset: no pin driven, bank at defaults
        chk_val({7'h0, sdio_oe_n_o & ro_oe_n_o}, 8'h01);
        chk_val({6'h0, readback_active_o, nv_write_en_o}, 8'h00);
        rd(`SCFG_ADR_CFG, `SCFG_CFG_RST);
        rd(`SCFG_ADR_RBK, `SCFG_RBK_RST);
        rd(`SCFG_ADR_NVC1, `SCFG_NV_RST);
        rd(`SCFG_ADR_NVC2, `SCFG_NV_RST);
        $display("test reset done");
        // ids: two byte read steps the address down; writes refused
        u_scfg_host.frame(1'b1, 2'h1, `SCFG_ADR_VID, 32'h0, lsb, sep, q);
        chk_val(q[7:0], VID);
        chk_val(q[15:8], REV);
        wr(`SCFG_ADR_VID, ~VID);
        rd(`SCFG_ADR_VID, VID);
        wr(`SCFG_ADR_REV, ~REV);
        rd(`SCFG_ADR_REV, REV);
        $display("test ids done");
        // random flags, readback select and unmapped reads
        for (i = 0; i < 6; i++) begin
            seed = xs(seed);
            x = seed;
            @(negedge clk_i);
            nv_busy_i = x[0];
            nv_error_i = x[1];
            rd(`SCFG_ADR_NVST, {7'h0, x[0]});
            rd(`SCFG_ADR_NVER, {7'h0, x[1]});
            wr(`SCFG_ADR_RBK, {7'h0, x[2]});
            chk_val({7'h0, readback_active_o}, {7'h0, x[2]});
            rd(`SCFG_ADR_RBK, {7'h0, x[2]});
            rd(13'h010 + {4'h0, x[12:4]}, 8'h00);
        end
        $display("test random done");
        // staged vs active write enable, copy gate, self clearing
        wr(`SCFG_ADR_RBK, 8'h00);
        wr(`SCFG_ADR_NVC1, 8'h01);
        rd(`SCFG_ADR_NVC1, 8'h01);
        wr(`SCFG_ADR_RBK, 8'h01);
        rd(`SCFG_ADR_NVC1, 8'h00);
        wr(`SCFG_ADR_NVC2, 8'h01);
        chk_cnt(n_copy, 0);
        @(negedge clk_i);
        io_update_i = 1'b1;
        @(negedge clk_i);
        io_update_i = 1'b0;
        chk_val({7'h0, nv_write_en_o}, 8'h01);
        rd(`SCFG_ADR_NVC1, 8'h01);
        wr(`SCFG_ADR_NVC2, 8'h01);
        chk_cnt(n_copy, 1);
        rd(`SCFG_ADR_NVC2, 8'h00);
        wr(`SCFG_ADR_RBK, 8'h00);
        wr(`SCFG_ADR_NVC1, 8'h03);
        chk_cnt(n_load, 1);
        rd(`SCFG_ADR_NVC1, 8'h01);
        $display("test nv done");
        // separate readout pin, mirrored nibble written by the host
        wr(`SCFG_ADR_CFG, 8'h81);
        sep = 1'b1;
        s_sd = n_sd;
        s_ro = n_ro;
        rd(`SCFG_ADR_CFG, 8'h81);
        chk_cnt(n_sd, s_sd);
        chk_val({7'h0, n_ro > s_ro}, 8'h01);
        wr(`SCFG_ADR_CFG, 8'h00);
        sep = 1'b0;
        s_sd = n_sd;
        s_ro = n_ro;
        rd(`SCFG_ADR_REV, REV);
        chk_cnt(n_ro, s_ro);
        chk_val({7'h0, n_sd > s_sd}, 8'h01);
        $display("test pins done");
        // lsb first: address steps up
        wr(`SCFG_ADR_CFG, 8'h42);
        lsb = 1'b1;
        u_scfg_host.frame(1'b1, 2'h1, `SCFG_ADR_REV, 32'h0, lsb, sep, q);
        chk_val(q[7:0], REV);
        chk_val(q[15:8], VID);
        u_scfg_host.frame(1'b0, 2'h1, `SCFG_ADR_VID, 32'h01FE, lsb, sep, q);
        chk_val({7'h0, readback_active_o}, 8'h01);
        // strap forces msb first whatever bit 6 says
        @(negedge clk_i);
        i2c_mode_i = 1'b1;
        lsb = 1'b0;
        repeat (4) @(negedge clk_i);
        u_scfg_host.frame(1'b1, 2'h1, `SCFG_ADR_VID, 32'h0, lsb, sep, q);
        chk_val(q[7:0], VID);
        chk_val(q[15:8], REV);
        i2c_mode_i = 1'b0;
        lsb = 1'b1;
        repeat (4) @(negedge clk_i);
        $display("test order done");
        // soft reset fires at the next frame's first rise
        wr(`SCFG_ADR_CFG, 8'h24);
        lsb = 1'b0;
        chk_cnt(n_srst, 0);
        chk_val({7'h0, readback_active_o}, 8'h01);
        rd(`SCFG_ADR_CFG, 8'h00);
        chk_cnt(n_srst, 1);
        chk_val({6'h0, readback_active_o, nv_write_en_o}, 8'h00);
        rd(`SCFG_ADR_RBK, 8'h00);
        $display("test soft reset done");
        end_of_test;
    end
endmodule : scfg_top_tb
